// ### hw/gsrpr_pkg.sv
// Purpose: shared constants and types for the service-request and poll-response block
// Assumes: one clock (aclk, 10 MHz), synchronous active-low reset
// Notes: link carries wired-or style SRQ and an eight-line parallel poll bus
package gsrpr_pkg;
  localparam int unsigned GSRPR_CLK_HZ = 10_000_000;
  localparam int unsigned GSRPR_SRQ_BIT = 6;
  localparam int unsigned GSRPR_SENSE_BIT = 3;
  localparam int unsigned GSRPR_DIS_BIT = 4;
  localparam logic [7:0] GSRPR_STATUS_RST = 8'h00;
  localparam logic [7:0] GSRPR_PPCFG_RST = 8'h10;
  localparam logic [7:0] GSRPR_LINE_OK_DEFAULT = 8'hff;
  localparam logic [7:0] GSRPR_PPCFG_MASK = 8'h1f;
  // controller-side register word offsets (byte addresses)
  localparam logic [3:0] GSRPR_REG_CTRL = 4'h0;
  localparam logic [3:0] GSRPR_REG_PPCFG = 4'h4;
  localparam logic [3:0] GSRPR_REG_STAT = 4'h8;
  localparam logic [3:0] GSRPR_REG_SPOLL = 4'hc;
  localparam logic [1:0] GSRPR_RESP_OKAY = 2'h0;
  localparam logic [1:0] GSRPR_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {GSRPR_CMD_NONE, GSRPR_CMD_SPOLL, GSRPR_CMD_PPOLL, GSRPR_CMD_PPCFG} gsrpr_cmd_t;
endpackage

// ### hw/gsrpr_if.sv
// Purpose: link between the device end and the active controller end
// Assumes: open-drain lines resolved here from output enables (low enable drives srq low, or a poll line to its data value)
// Notes: srq is asserted-low on the wire; dio is true-level poll data
`timescale 1ns/1ps
`default_nettype none
interface gsrpr_if;
  logic srq_oe_n_dev; // device pulls srq low when 0
  logic srq_oe_n_other; // other bus requesters, driven by bench
  logic srq_n; // resolved wired-or request, low = asserted
  logic [7:0] pp_data; // device parallel poll drive value
  logic [7:0] pp_oe_n; // device drives a poll line where 0
  logic [7:0] pp_bus; // resolved parallel poll lines (data gated by enables)
  gsrpr_pkg::gsrpr_cmd_t cmd; // controller command
  logic [7:0] cmd_data; // command payload (remote config)
  logic cmd_valid; // one-cycle command strobe
  logic [7:0] spoll_byte; // serial poll answer
  logic spoll_valid; // answer strobe
  logic ctl_active; // device holds controller role
  assign srq_n = srq_oe_n_dev & srq_oe_n_other;
  assign pp_bus = pp_data & ~pp_oe_n;
  modport dev (output srq_oe_n_dev, output pp_data, output pp_oe_n, output spoll_byte, output spoll_valid,
    input srq_n, input cmd, input cmd_data, input cmd_valid, input ctl_active);
  modport ctl (input srq_n, input pp_bus, input spoll_byte, input spoll_valid,
    output cmd, output cmd_data, output cmd_valid);
endinterface
`default_nettype wire

// ### hw/gsrpr_dev.sv
// Purpose: device end: status byte, SRQ drive, serial and parallel poll answers
// Assumes: host writes are single-cycle strobes; ctl_active comes from the bench
// Notes: line_ok tells which poll lines the hardware can drive
`timescale 1ns/1ps
`default_nettype none
module gsrpr_dev (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  gsrpr_if.dev bus, // link side
  input wire logic [31:0] st_wdata, // status value from host
  input wire logic st_we, // status write strobe
  input wire logic [31:0] cfg_wdata, // poll config from host
  input wire logic cfg_we, // config write strobe
  input wire logic svc_flag, // service flag value
  input wire logic svc_we, // service flag write strobe
  input wire logic [7:0] line_ok, // drivable poll lines
  output logic cfg_err, // one-cycle invalid-argument pulse
  output logic [7:0] status_q_o, // current status byte
  output logic srq_pending // stored request bit
);
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] ppcfg;
    logic svc;
    logic err;
    logic srq_oe_n;
    logic [7:0] pp_data;
    logic [7:0] pp_oe_n;
    logic [7:0] sp_byte;
    logic sp_valid;
  } gsrpr_dev_st_t;
  gsrpr_dev_st_t st_q, st_d;

  always_comb begin
    logic service;
    service = 1'b0;
    st_d = st_q;
    st_d.err = 1'b0;
    st_d.sp_valid = 1'b0;
    if (st_we) begin
      st_d.status = st_wdata[7:0];
    end
    if (cfg_we) begin
      if (line_ok[cfg_wdata[2:0]]) begin
        st_d.ppcfg = cfg_wdata[7:0] & gsrpr_pkg::GSRPR_PPCFG_MASK;
      end else begin
        st_d.err = 1'b1;
      end
    end
    if (svc_we) begin
      st_d.svc = svc_flag;
    end
    if (bus.cmd_valid && !bus.ctl_active) begin
      case (bus.cmd)
        gsrpr_pkg::GSRPR_CMD_SPOLL: begin
          st_d.sp_byte = st_q.status;
          st_d.sp_valid = 1'b1;
          // polling clears the request unless the host writes in the same cycle
          if (!st_we) begin
            st_d.status[gsrpr_pkg::GSRPR_SRQ_BIT] = 1'b0;
          end
        end
        gsrpr_pkg::GSRPR_CMD_PPCFG: begin
          if (!cfg_we) begin
            st_d.ppcfg = bus.cmd_data & gsrpr_pkg::GSRPR_PPCFG_MASK;
          end
        end
        default: begin
        end
      endcase
    end
    // only stored while controller; driven as soon as control is given up
    st_d.srq_oe_n = !(st_d.status[gsrpr_pkg::GSRPR_SRQ_BIT] && !bus.ctl_active);
    service = st_d.svc && !st_d.ppcfg[gsrpr_pkg::GSRPR_DIS_BIT];
    st_d.pp_oe_n = '1;
    st_d.pp_data = '0;
    if (!bus.ctl_active) begin
      st_d.pp_oe_n[st_d.ppcfg[2:0]] = 1'b0;
      // the selected line is enabled for either answer; data is 1 when service equals the sense bit
      st_d.pp_data[st_d.ppcfg[2:0]] = service ~^ st_d.ppcfg[gsrpr_pkg::GSRPR_SENSE_BIT];
    end
    if (!aresetn) begin
      st_d = '0;
      st_d.status = gsrpr_pkg::GSRPR_STATUS_RST;
      st_d.ppcfg = gsrpr_pkg::GSRPR_PPCFG_RST;
      st_d.srq_oe_n = 1'b1;
      st_d.pp_oe_n = '1;
    end
  end

  always_ff @(posedge aclk) begin
    st_q <= st_d;
  end

  assign bus.srq_oe_n_dev = st_q.srq_oe_n;
  assign bus.pp_data = st_q.pp_data;
  assign bus.pp_oe_n = st_q.pp_oe_n;
  assign bus.spoll_byte = st_q.sp_byte;
  assign bus.spoll_valid = st_q.sp_valid;
  assign cfg_err = st_q.err;
  assign status_q_o = st_q.status;
  assign srq_pending = st_q.status[gsrpr_pkg::GSRPR_SRQ_BIT];
endmodule
`default_nettype wire

// ### hw/gsrpr_ctl.sv
// Purpose: active controller end, steered from AXI4-Lite registers
// Assumes: single outstanding read and write; answers in fixed latency
// Notes: commands go out as one-cycle strobes; answers latched for the SPOLL register
`timescale 1ns/1ps
`default_nettype none
module gsrpr_ctl (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  gsrpr_if.ctl bus, // link side
  input wire logic [3:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [3:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read response valid
  input wire logic s_axi_rready // read response ready
);
  typedef struct packed {
    logic aw_got;
    logic [3:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    gsrpr_pkg::gsrpr_cmd_t cmd;
    logic [7:0] cmd_data;
    logic cmd_valid;
    logic [7:0] spoll;
    logic spoll_new;
  } gsrpr_ctl_st_t;
  gsrpr_ctl_st_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.cmd_valid = 1'b0;
    if (s_axi_awvalid && !st_q.aw_got && !st_q.bvalid) begin
      st_d.aw_got = 1'b1;
      st_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.w_got && !st_q.bvalid) begin
      st_d.w_got = 1'b1;
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end
    if (st_q.aw_got && st_q.w_got) begin
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = gsrpr_pkg::GSRPR_RESP_OKAY;
      case (st_q.awaddr)
        gsrpr_pkg::GSRPR_REG_CTRL: begin
          if (st_q.wstrb[0]) begin
            st_d.cmd = gsrpr_pkg::gsrpr_cmd_t'(st_q.wdata[1:0]);
            st_d.cmd_valid = 1'b1;
          end
        end
        gsrpr_pkg::GSRPR_REG_PPCFG: begin
          if (st_q.wstrb[0]) begin
            st_d.cmd_data = st_q.wdata[7:0];
          end
        end
        default: st_d.bresp = gsrpr_pkg::GSRPR_RESP_SLVERR;
      endcase
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (bus.spoll_valid) begin
      st_d.spoll = bus.spoll_byte;
      st_d.spoll_new = 1'b1;
    end
    if (s_axi_arvalid && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = gsrpr_pkg::GSRPR_RESP_OKAY;
      case (s_axi_araddr)
        gsrpr_pkg::GSRPR_REG_CTRL: st_d.rdata = {30'h0, st_q.cmd};
        gsrpr_pkg::GSRPR_REG_PPCFG: st_d.rdata = {24'h0, st_q.cmd_data};
        // srq seen and shared poll lines let software pick whom to poll
        gsrpr_pkg::GSRPR_REG_STAT: st_d.rdata = {22'h0, st_q.spoll_new, !bus.srq_n, bus.pp_bus};
        gsrpr_pkg::GSRPR_REG_SPOLL: begin
          st_d.rdata = {24'h0, st_q.spoll};
          st_d.spoll_new = bus.spoll_valid;
        end
        default: begin
          st_d.rdata = 32'h0;
          st_d.rresp = gsrpr_pkg::GSRPR_RESP_SLVERR;
        end
      endcase
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (!aresetn) begin
      st_d = '0;
    end
  end

  always_ff @(posedge aclk) begin
    st_q <= st_d;
  end

  assign s_axi_awready = st_q.aw_got == 1'b0 && !st_q.bvalid;
  assign s_axi_wready = st_q.w_got == 1'b0 && !st_q.bvalid;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign bus.cmd = st_q.cmd;
  assign bus.cmd_data = st_q.cmd_data;
  assign bus.cmd_valid = st_q.cmd_valid;
endmodule
`default_nettype wire

// ### bench/gsrpr_monitor.sv
// Purpose: link checker
// Assumes: one clock, sync reset low
// Notes: host-side causes are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module gsrpr_monitor (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic srq_oe_n_dev, // dev pull
  input wire logic srq_oe_n_other, // others pull
  input wire logic srq_n, // request line
  input wire logic [7:0] pp_oe_n, // poll enables, low drives
  input wire logic [7:0] pp_bus, // poll lines
  input wire gsrpr_pkg::gsrpr_cmd_t cmd, // command
  input wire logic cmd_valid, // command strobe
  input wire logic spoll_valid, // answer strobe
  input wire logic ctl_active // controller role
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst; !$past(aresetn) |-> srq_oe_n_dev; endproperty
  a_rst: assert property (p_rst) else $error("srq driven after reset");
  property p_ctl_srq; ctl_active && $past(ctl_active) |-> srq_oe_n_dev; endproperty
  a_ctl_srq: assert property (p_ctl_srq) else $error("srq driven as controller");
  property p_srq_fall; $fell(srq_oe_n_dev) |-> !$past(ctl_active); endproperty
  a_srq_fall: assert property (p_srq_fall) else $error("srq raised as controller");
  property p_ctl_pp; ctl_active && $past(ctl_active) |-> pp_bus == 8'h00; endproperty
  a_ctl_pp: assert property (p_ctl_pp) else $error("poll answer as controller");
  property p_wired; !srq_oe_n_other |-> !srq_n; endproperty
  a_wired: assert property (p_wired) else $error("shared srq lost");
  property p_line; $onehot0(~pp_oe_n); endproperty
  a_line: assert property (p_line) else $error("poll on several lines");
  property p_poll; cmd_valid && cmd == gsrpr_pkg::GSRPR_CMD_SPOLL && !ctl_active |=> spoll_valid; endproperty
  a_poll: assert property (p_poll) else $error("serial poll unanswered");
  property p_poll_ign; cmd_valid && ctl_active |=> !spoll_valid; endproperty
  a_poll_ign: assert property (p_poll_ign) else $error("poll answered as controller");
  c_poll: cover property (cmd_valid ##1 spoll_valid);
  c_shared: cover property (!srq_oe_n_other && !srq_oe_n_dev);
  c_hand: cover property ($fell(ctl_active) ##2 !srq_oe_n_dev);
endmodule
`default_nettype wire

// ### bench/tb_gpib_service_request_poll_resp.sv
// Purpose: bench for both ends joined by the link
// Assumes: 10 MHz aclk, reset held 16 cycles
// Notes: read data checked from a queue by a watcher
`timescale 1ns/1ps
`default_nettype none
module tb_gpib_service_request_poll_resp;
  logic aclk, aresetn, st_we, cfg_we, svc_flag, svc_we, cfg_err, srq_pending;
  logic [31:0] st_wdata, cfg_wdata, s_axi_wdata, s_axi_rdata, rnd;
  logic [7:0] line_ok, status_q_o;
  logic [3:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  localparam logic [1:0] r_ok = gsrpr_pkg::GSRPR_RESP_OKAY;
  localparam logic [1:0] r_err = gsrpr_pkg::GSRPR_RESP_SLVERR;
  integer seed = 32'h06c1f6a7, errors = 0, samples_checked = 0, err_cnt = 0, n0;
  gsrpr_if bus_if();
  gsrpr_dev i_gsrpr_dev(.*, .bus(bus_if));
  gsrpr_ctl i_gsrpr_ctl(.*, .bus(bus_if), .s_axi_wstrb(4'hf));
  gsrpr_monitor i_gsrpr_monitor(.aclk(aclk), .aresetn(aresetn), .srq_oe_n_dev(bus_if.srq_oe_n_dev),
    .srq_oe_n_other(bus_if.srq_oe_n_other), .srq_n(bus_if.srq_n), .pp_oe_n(bus_if.pp_oe_n),
    .pp_bus(bus_if.pp_bus), .cmd(bus_if.cmd), .cmd_valid(bus_if.cmd_valid),
    .spoll_valid(bus_if.spoll_valid), .ctl_active(bus_if.ctl_active));
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    samples_checked++;
    if (s !== x) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic results;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // k: 0 status, 1 poll config, 2 service flag; upper bits random to show they are ignored
  task automatic hst(input logic [1:0] k, input logic [7:0] v);
    @(posedge aclk);
    rnd = $random(seed);
    st_wdata <= {rnd[31:8], v};
    cfg_wdata <= {rnd[31:8], v};
    svc_flag <= v[0];
    st_we <= (k == 2'd0);
    cfg_we <= (k == 2'd1);
    svc_we <= (k == 2'd2);
    @(posedge aclk);
    {st_we, cfg_we, svc_we} <= 3'b000;
    repeat (2) @(posedge aclk);
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk("bresp", r, s_axi_bresp);
    // let the issued command reach the device end
    repeat (3) @(posedge aclk);
  endtask
  task automatic axr(input logic [3:0] a, input logic [1:0] r, input logic [31:0] d);
    exp_q.push_back({r, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e = exp_q.pop_front();
      chk("rresp", e[33:32], s_axi_rresp);
      if (e[33:32] == r_ok) chk("rdata", e[31:0], s_axi_rdata);
    end
    if (cfg_err === 1'b1) err_cnt++;
  end
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    #2000000;
    errors++;
    results();
  end
  initial begin
    {aresetn, st_we, cfg_we, svc_we, svc_flag, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {st_wdata, cfg_wdata, s_axi_wdata} = '0;
    line_ok = 8'hff;
    bus_if.srq_oe_n_other = 1'b1;
    bus_if.ctl_active = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axr(gsrpr_pkg::GSRPR_REG_STAT, r_ok, 32'h1);
    hst(0, 8'h4a);
    chk("status", 8'h4a, status_q_o);
    chk("srq_n", 0, bus_if.srq_n);
    axr(gsrpr_pkg::GSRPR_REG_STAT, r_ok, 32'h101);
    axw(gsrpr_pkg::GSRPR_REG_CTRL, 32'h1, r_ok);
    axr(gsrpr_pkg::GSRPR_REG_STAT, r_ok, 32'h201);
    axr(gsrpr_pkg::GSRPR_REG_SPOLL, r_ok, 32'h4a);
    chk("status", 8'h0a, status_q_o);
    bus_if.srq_oe_n_other <= 1'b0;
    hst(0, 8'h40);
    axw(gsrpr_pkg::GSRPR_REG_CTRL, 32'h1, r_ok);
    chk("srq_pending", 0, srq_pending);
    chk("srq_n", 0, bus_if.srq_n);
    bus_if.srq_oe_n_other <= 1'b1;
    @(posedge aclk);
    @(posedge aclk);
    chk("srq_n", 1, bus_if.srq_n);
    hst(0, 8'h40);
    hst(0, 8'h00);
    chk("srq_n", 1, bus_if.srq_n);
    bus_if.ctl_active <= 1'b1;
    hst(0, 8'h41);
    axw(gsrpr_pkg::GSRPR_REG_CTRL, 32'h1, r_ok);
    chk("srq_n", 1, bus_if.srq_n);
    chk("srq_pending", 1, srq_pending);
    bus_if.ctl_active <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("srq_n", 0, bus_if.srq_n);
    axw(gsrpr_pkg::GSRPR_REG_CTRL, 32'h1, r_ok);
    axr(gsrpr_pkg::GSRPR_REG_SPOLL, r_ok, 32'h41);
    for (int i = 0; i < 32; i++) begin
      hst(2, {7'h0, i[3]});
      hst(1, {4'b1110, i[4], i[2:0]});
      chk("pp_bus", {7'h0, i[3] ~^ i[4]} << i[2:0], bus_if.pp_bus);
      hst(2, 8'h1);
      hst(1, {4'b0001, i[4], i[2:0]});
      chk("pp_bus", {7'h0, !i[4]} << i[2:0], bus_if.pp_bus);
    end
    bus_if.ctl_active <= 1'b1;
    hst(1, 8'h0d);
    chk("pp_bus", 0, bus_if.pp_bus);
    bus_if.ctl_active <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("pp_bus", 8'h20, bus_if.pp_bus);
    line_ok <= 8'hf7;
    n0 = err_cnt;
    hst(1, 8'h0b);
    chk("cfg_err", n0 + 1, err_cnt);
    chk("pp_bus", 8'h20, bus_if.pp_bus);
    line_ok <= 8'hff;
    axw(gsrpr_pkg::GSRPR_REG_PPCFG, 32'h0e, r_ok);
    for (int c = 3; c >= 0; c--) axw(gsrpr_pkg::GSRPR_REG_CTRL, c, r_ok);
    chk("pp_bus", 8'h40, bus_if.pp_bus);
    axr(gsrpr_pkg::GSRPR_REG_STAT, r_ok, 32'h240);
    axr(gsrpr_pkg::GSRPR_REG_PPCFG, r_ok, 32'h0e);
    axr(gsrpr_pkg::GSRPR_REG_CTRL, r_ok, 32'h0);
    axr(4'h2, r_err, 32'h0);
    axw(4'h6, 32'h0, r_err);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(gsrpr_pkg::GSRPR_REG_STAT, r_ok, 32'h1);
    chk("status", 8'h0, status_q_o);
    results();
  end
endmodule
`default_nettype wire
